//--- verilog/pcuer_top.v
// Uncorrectable error reporting registers with an AHB-Lite slave port
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pcuer_map.vh"

// Contract
// - FC credit infinite-to-finite update sets bit 13
// - Poisoned payload sets bit 12, first loads log
// - Bad ACK/NAK sequence number sets bit 4
// - Writing one clears status, zero keeps it
// - Status bits survive reset, cleared only by software or power-on
// - Training status bit 0 reads zero always
// - Masked error sends no message to root
// - Masked errors still set their status bit
// - Mask bits read-write at implemented positions
// - Mask and severity survive reset
// - Severity one means fatal, zero nonfatal
// - Severity reads 0006_2011h after initialization
// - Mask and severity bits 19, 0 read-only
module pcuer_top #(
  parameter ADDR_W = 12
) (
  input  wire              CLK,
  input  wire              RST,
  input  wire              POR,
  input  wire              HSEL,
  input  wire [ADDR_W-1:0] HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire [31:0]       HRDATA,
  output wire              HREADYOUT,
  output wire              HRESP,
  input  wire              UNSREQ_ERR,
  input  wire              MALTLP_ERR,
  input  wire              RXOVF_ERR,
  input  wire              UNXCPL_ERR,
  input  wire              CPLABT_ERR,
  input  wire              CPLTO_ERR,
  input  wire              FCPROT_ERR,
  input  wire              POISON_ERR,
  input  wire              DLPROT_ERR,
  output wire              ERR_FATAL_REQ,
  output wire              ERR_NONFATAL_REQ,
  output wire              HDR_LOG_LOAD,
  output wire [4:0]        FIRST_ERR_PTR,
  output wire              IRQ
);

  // Register select codes. Correctable status has a code of its own so
  // that it decodes, but it lives outside this block and reads zero
  localparam [2:0] SEL_NONE  = 3'h0;
  localparam [2:0] SEL_STAT  = 3'h1;
  localparam [2:0] SEL_MASK  = 3'h2;
  localparam [2:0] SEL_SEV   = 3'h3;
  localparam [2:0] SEL_FIRST = 3'h4;
  localparam [2:0] SEL_IRQM  = 3'h5;
  localparam [2:0] SEL_CORR  = 3'h6;

  localparam [31:0] IMPL   = `PCUER_IMPL_BITS;
  localparam [31:0] HDRLOG = `PCUER_HDRLOG_BITS;
  localparam [31:0] SEVRST = `PCUER_RST_SEVER;

  // Severity positions with no error behind them show their reset value
  // for ever: those positions read their default and ignore writes
  localparam [31:0] SEVFIX = SEVRST & ~IMPL;

  // Address decode, shared by the read mux and the write strobes
  // Sub-word addresses select the word that holds them
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    reg   [11:0]       w;
    begin
      w = {a[11:2], 2'b00};
      if (w == `PCUER_OFS_STATUS) begin
        reg_sel = SEL_STAT;
      end else if (w == `PCUER_OFS_MASK) begin
        reg_sel = SEL_MASK;
      end else if (w == `PCUER_OFS_SEVER) begin
        reg_sel = SEL_SEV;
      end else if (w == `PCUER_OFS_FIRST) begin
        reg_sel = SEL_FIRST;
      end else if (w == `PCUER_OFS_IRQMASK) begin
        reg_sel = SEL_IRQM;
      end else if (w == `PCUER_OFS_CORSTAT) begin
        reg_sel = SEL_CORR;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // Byte lanes touched by a write of the given size and low address
  // Reads always return the whole word, whatever the size
  function [31:0] lane_mask;
    input [2:0] sz;
    input [1:0] lo;
    begin
      if (sz == `PCUER_HSIZE_BYTE) begin
        lane_mask = 32'h000000ff << {lo, 3'b000};
      end else if (sz == `PCUER_HSIZE_HALF) begin
        lane_mask = 32'h0000ffff << {lo[1], 4'b0000};
      end else begin
        lane_mask = 32'hffffffff;
      end
    end
  endfunction

  // Lowest set bit index, used to record which error came first
  // The loop walks downwards so the lowest hit is the last one kept
  function [4:0] low_idx;
    input [31:0] v;
    integer      i;
    begin
      low_idx = 5'h00;
      for (i = 31; i >= 0; i = i - 1) begin
        if (v[i]) begin
          low_idx = i[4:0];
        end
      end
    end
  endfunction

  // Bus data-phase state
  // Address and size are kept here because the bus moves on
  reg              dp_wr_q;
  reg              dp_rd_q;
  reg [ADDR_W-1:0] dp_addr_q;
  reg [2:0]        dp_size_q;
  reg [31:0]       hrdata_q;

  // Block state not kept in the cells
  reg        fatal_q;
  reg        nonfatal_q;
  reg        hdrload_q;
  reg [4:0]  first_q;
  reg        first_vld_q;
  reg [31:0] irqmask_q;

  // Decode, strobe and per-bit error vectors
  wire        ap_take;
  wire [2:0]  dp_sel;
  wire [31:0] wr_lanes;
  wire [31:0] wbits;
  wire        wr_stat;
  wire        wr_mask;
  wire        wr_sev;
  wire        wr_irqm;
  wire [31:0] err_vec;
  wire [31:0] stat_vec;
  wire [31:0] mask_vec;
  wire [31:0] sev_vec;
  wire [31:0] rep_vec;
  wire        any_stat;
  wire        fatal_d;
  wire        nonfatal_d;
  wire        first_evt;
  reg  [31:0] rd_mux;

  // Detection pulses from the link and transaction layers
  assign err_vec = {11'h000,
                    UNSREQ_ERR,     // bit 20
                    1'b0,           // bit 19, no end-to-end CRC check
                    MALTLP_ERR,
                    RXOVF_ERR,
                    UNXCPL_ERR,
                    CPLABT_ERR,
                    CPLTO_ERR,
                    FCPROT_ERR,
                    POISON_ERR,
                    7'h00,
                    DLPROT_ERR,
                    3'h0,
                    1'b0};

  // Address phase is taken only when the bus is ready
  assign ap_take = HSEL & HTRANS[1] & HREADY;

  // Data-phase capture. Only a taken address phase arms a strobe, so
  // idle slots never write; the read flag drops after its one wait
  // cycle so that the next address phase can be taken
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= {ADDR_W{1'b0}};
      dp_size_q <= 3'h0;
    end else begin
      if (HREADYOUT) begin
        dp_wr_q <= ap_take & HWRITE;
        dp_rd_q <= ap_take & ~HWRITE;
        if (ap_take) begin
          dp_addr_q <= HADDR;
          dp_size_q <= HSIZE;
        end
      end else begin
        dp_rd_q <= 1'b0;
      end
    end
  end

  // One wait state on reads so a write just before is always seen
  // Writes finish with no wait; every address answers OKAY, unmapped
  // ones with zero, so the error response is never used
  assign HREADYOUT = ~dp_rd_q;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_q;

  // Write strobes during the data phase
  // They act at the end of the data phase, where HWDATA stands
  assign dp_sel   = reg_sel(dp_addr_q);
  assign wr_lanes = lane_mask(dp_size_q, dp_addr_q[1:0]);
  assign wbits    = HWDATA & wr_lanes;
  assign wr_stat  = dp_wr_q & (dp_sel == SEL_STAT);
  assign wr_mask  = dp_wr_q & (dp_sel == SEL_MASK);
  assign wr_sev   = dp_wr_q & (dp_sel == SEL_SEV);
  assign wr_irqm  = dp_wr_q & (dp_sel == SEL_IRQM);

  // Sticky cells only where an error exists; other bits are constant
  // No flop sits at the other positions, so reserved and read-only
  // bits stay put whatever software writes there
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_bit
      if (IMPL[g]) begin : g_cell
        pcuer_err_cell #(
          .SEV_RST (SEVRST[g])
        ) u_cell (
          .clk     (CLK),
          .por     (POR),
          .evt     (err_vec[g]),
          .wr_stat (wr_stat & wr_lanes[g]),
          .wr_mask (wr_mask & wr_lanes[g]),
          .wr_sev  (wr_sev & wr_lanes[g]),
          .wbit    (HWDATA[g]),
          .stat_q  (stat_vec[g]),
          .mask_q  (mask_vec[g]),
          .sev_q   (sev_vec[g])
        );
      end else begin : g_none
        assign stat_vec[g] = 1'b0;
        assign mask_vec[g] = 1'b0;
        assign sev_vec[g]  = 1'b0;
      end
    end
  endgenerate

  // Errors that go to the root; masking gates the message, not the log
  // Several errors in one cycle share one message of each severity;
  // the root only learns that at least one of them happened
  assign rep_vec    = err_vec & ~mask_vec & IMPL;
  assign fatal_d    = |(rep_vec & sev_vec);
  assign nonfatal_d = |(rep_vec & ~sev_vec);

  // First error: none logged before and nothing captured yet
  // Errors landing together count as one; the lowest index is kept
  assign any_stat  = |(stat_vec & IMPL);
  assign first_evt = ~any_stat & ~first_vld_q & (|(err_vec & IMPL));

  // Message and header-log requests are one-cycle pulses
  // A detect input held high repeats its message every cycle, so the
  // sources must pulse once per event
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      fatal_q    <= 1'b0;
      nonfatal_q <= 1'b0;
      hdrload_q  <= 1'b0;
    end else begin
      fatal_q    <= fatal_d;
      nonfatal_q <= nonfatal_d;
      hdrload_q  <= first_evt & (|(err_vec & HDRLOG));
    end
  end

  // First-error pointer; rearms once software has cleared all status
  // Pointer and status both ignore the functional reset, so a log
  // taken before a reset still names its first error afterwards
  always @(posedge CLK or posedge POR) begin
    if (POR) begin
      first_q     <= `PCUER_RST_FIRST;
      first_vld_q <= 1'b0;
    end else begin
      if (first_evt) begin
        first_q     <= low_idx(err_vec & IMPL);
        first_vld_q <= 1'b1;
      end else if (~any_stat & first_vld_q & ~wr_stat) begin
        first_vld_q <= 1'b0;
      end
    end
  end

  // Interrupt mask is plain control and follows the functional reset
  // It is not sticky: after a functional reset every logged error
  // interrupts again until software masks it once more
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      irqmask_q <= `PCUER_RST_IRQMASK;
    end else if (wr_irqm) begin
      irqmask_q <= (irqmask_q & ~wr_lanes) | (wbits & IMPL);
    end
  end

  // Level interrupt while any logged error is not masked here
  assign IRQ = |(stat_vec & ~irqmask_q & IMPL);

  // Read mux; the correctable register is outside this block
  always @* begin
    rd_mux = 32'h00000000;
    case (dp_sel)
      SEL_STAT:  rd_mux = stat_vec & IMPL;
      SEL_MASK:  rd_mux = mask_vec & IMPL;
      SEL_SEV:   rd_mux = (sev_vec & IMPL) | SEVFIX;
      SEL_FIRST: rd_mux = {26'h0000000, first_vld_q, first_q};
      SEL_IRQM:  rd_mux = irqmask_q;
      default:   rd_mux = 32'h00000000;
    endcase
  end

  // Read data is registered in the wait cycle
  // Registering costs the wait state but keeps the mux off the bus path
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      hrdata_q <= 32'h00000000;
    end else if (dp_rd_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // Requests, strobe and pointer all leave straight from flops
  assign ERR_FATAL_REQ    = fatal_q;
  assign ERR_NONFATAL_REQ = nonfatal_q;
  assign HDR_LOG_LOAD     = hdrload_q;
  assign FIRST_ERR_PTR    = first_q;

endmodule

`default_nettype wire

//--- verilog/pcuer_map.vh
// Register map, field layout and reset values of the error report block
`ifndef PCUER_MAP_VH
`define PCUER_MAP_VH

// Register byte offsets in the function's configuration space
`define PCUER_OFS_STATUS   12'h104
`define PCUER_OFS_MASK     12'h108
`define PCUER_OFS_SEVER    12'h10c
`define PCUER_OFS_CORSTAT  12'h110
`define PCUER_OFS_FIRST    12'h118
`define PCUER_OFS_IRQMASK  12'h11c

// Error bit positions
`define PCUER_BIT_TRAIN    0
`define PCUER_BIT_DLPROT   4
`define PCUER_BIT_POISON   12
`define PCUER_BIT_FCPROT   13
`define PCUER_BIT_CPLTO    14
`define PCUER_BIT_CPLABT   15
`define PCUER_BIT_UNXCPL   16
`define PCUER_BIT_RXOVF    17
`define PCUER_BIT_MALTLP   18
`define PCUER_BIT_ECRC     19
`define PCUER_BIT_UNSREQ   20

// Bits that exist; everything else ignores writes and reads zero, except severity bit 0, which reads one
`define PCUER_IMPL_BITS    32'h0017f010
// Errors that load the header log when they are the first one
`define PCUER_HDRLOG_BITS  32'h00179000

// Reset values
`define PCUER_RST_STATUS   32'h00000000
`define PCUER_RST_MASK     32'h00000000
`define PCUER_RST_SEVER    32'h00062011
`define PCUER_RST_IRQMASK  32'h00000000
`define PCUER_RST_FIRST    5'h00

// AHB-Lite encodings
`define PCUER_HSIZE_BYTE   3'h0
`define PCUER_HSIZE_HALF   3'h1
`define PCUER_HSIZE_WORD   3'h2

`endif

//--- verilog/pcuer_err_cell.v
// One implemented error bit: sticky status, mask and severity flops
`timescale 1ns/100ps
`default_nettype none

module pcuer_err_cell #(
  parameter SEV_RST = 1'b0
) (
  input  wire clk,
  input  wire por,
  input  wire evt,
  input  wire wr_stat,
  input  wire wr_mask,
  input  wire wr_sev,
  input  wire wbit,
  output reg  stat_q,
  output reg  mask_q,
  output reg  sev_q
);

  wire stat_d;

  // Set wins over a same-cycle clear so no error is lost
  assign stat_d = (stat_q & ~(wr_stat & wbit)) | evt;

  // Only power-on resets these; the functional reset leaves them alone
  always @(posedge clk or posedge por) begin
    if (por) begin
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      sev_q  <= SEV_RST;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= wbit;
      end
      if (wr_sev) begin
        sev_q <= wbit;
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/pcuer_link_model.sv
// Far-side model: raises error detect pulses and counts message requests
`timescale 1ns/100ps
`default_nettype none
module pcuer_link_model (
  input  wire logic        clk,
  input  wire logic        fat,
  input  wire logic        nfat,
  input  wire logic        hdr,
  output logic      [20:0] err
);
  int n_fat;
  int n_nfat;
  int n_hdr;
  initial err = 21'h000000;
  // One-cycle detect pulse launched just after an edge
  task automatic pulse(input logic [20:0] v);
    @(posedge clk);
    err <= v;
    @(posedge clk);
    err <= 21'h000000;
  endtask
  // Root side: count every message and log strobe seen
  always @(posedge clk) begin
    n_fat  <= n_fat + int'(fat === 1'b1);
    n_nfat <= n_nfat + int'(nfat === 1'b1);
    n_hdr  <= n_hdr + int'(hdr === 1'b1);
  end
endmodule
`default_nettype wire

//--- tb/pcuer_asserts.sv
// Concurrent checks on the error report block's ports
`timescale 1ns/100ps
`default_nettype none
module pcuer_asserts (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       POR,
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       UNSREQ_ERR,
  input wire logic       MALTLP_ERR,
  input wire logic       RXOVF_ERR,
  input wire logic       UNXCPL_ERR,
  input wire logic       CPLABT_ERR,
  input wire logic       CPLTO_ERR,
  input wire logic       FCPROT_ERR,
  input wire logic       POISON_ERR,
  input wire logic       DLPROT_ERR,
  input wire logic       ERR_FATAL_REQ,
  input wire logic       ERR_NONFATAL_REQ,
  input wire logic       HDR_LOG_LOAD
);
  // Errors that may load the header log, and all errors
  wire logic hdr_e = UNSREQ_ERR | MALTLP_ERR | RXOVF_ERR | UNXCPL_ERR
                     | CPLABT_ERR | POISON_ERR;
  wire logic any_e = hdr_e | CPLTO_ERR | FCPROT_ERR | DLPROT_ERR;
  wire logic take  = HSEL & HTRANS[1] & HREADY;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || POR);
  AST_FATAL_CAUSE:
    assert property (ERR_FATAL_REQ |-> $past(any_e))
    else $error("fatal request with no error before it");
  AST_NONFATAL_CAUSE:
    assert property (ERR_NONFATAL_REQ |-> $past(any_e))
    else $error("nonfatal request with no error before it");
  AST_HDR_CAUSE:
    assert property (HDR_LOG_LOAD |-> $past(hdr_e))
    else $error("header log load without a logging error");
  AST_NO_HDR_LINK:
    assert property (any_e && !hdr_e |=> !HDR_LOG_LOAD)
    else $error("header log loaded by a link-level error");
  AST_REQ_QUIET:
    assert property (@(posedge CLK) disable iff (POR)
      RST |-> !ERR_FATAL_REQ && !ERR_NONFATAL_REQ)
    else $error("message request during reset");
  AST_RD_WAIT:
    assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not one wait state");
  AST_WR_NOWAIT:
    assert property (take && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  AST_OKAY:
    assert property (take |=> (!HRESP)[*2])
    else $error("error response given");
  cover property (ERR_FATAL_REQ);
  cover property (ERR_NONFATAL_REQ && HDR_LOG_LOAD);
  cover property (take && !HWRITE);
endmodule
bind pcuer_top pcuer_asserts u_chk (.CLK(CLK), .RST(RST), .POR(POR),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .UNSREQ_ERR(UNSREQ_ERR),
  .MALTLP_ERR(MALTLP_ERR), .RXOVF_ERR(RXOVF_ERR), .UNXCPL_ERR(UNXCPL_ERR),
  .CPLABT_ERR(CPLABT_ERR), .CPLTO_ERR(CPLTO_ERR), .FCPROT_ERR(FCPROT_ERR),
  .POISON_ERR(POISON_ERR), .DLPROT_ERR(DLPROT_ERR),
  .ERR_FATAL_REQ(ERR_FATAL_REQ), .ERR_NONFATAL_REQ(ERR_NONFATAL_REQ),
  .HDR_LOG_LOAD(HDR_LOG_LOAD));
`default_nettype wire

//--- tb/tb.sv
// Register-level testbench for the error report block
`timescale 1ns/100ps
`default_nettype none
`include "pcuer_map.vh"
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  logic        CLK = 0, RST = 1, POR = 1, HSEL = 0, HWRITE = 0;
  logic [11:0] HADDR = 12'h000;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HWDATA = 32'h00000000, rd, sv;
  wire logic [31:0] HRDATA;
  wire logic [20:0] err;
  wire logic [4:0]  FIRST_ERR_PTR;
  wire logic HREADYOUT, HRESP, ERR_FATAL_REQ, ERR_NONFATAL_REQ;
  wire logic HDR_LOG_LOAD, IRQ;
  int error_cnt, n_checks, cyc, nf, nn, nh;
  pcuer_top DUT (.CLK(CLK), .RST(RST), .POR(POR), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .UNSREQ_ERR(err[20]),
    .MALTLP_ERR(err[18]), .RXOVF_ERR(err[17]), .UNXCPL_ERR(err[16]),
    .CPLABT_ERR(err[15]), .CPLTO_ERR(err[14]), .FCPROT_ERR(err[13]),
    .POISON_ERR(err[12]), .DLPROT_ERR(err[4]), .ERR_FATAL_REQ(ERR_FATAL_REQ),
    .ERR_NONFATAL_REQ(ERR_NONFATAL_REQ), .HDR_LOG_LOAD(HDR_LOG_LOAD),
    .FIRST_ERR_PTR(FIRST_ERR_PTR), .IRQ(IRQ));
  pcuer_link_model lm (.clk(CLK), .fat(ERR_FATAL_REQ),
    .nfat(ERR_NONFATAL_REQ), .hdr(HDR_LOG_LOAD), .err(err));
  initial forever #12.5 CLK = ~CLK;
  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Single AHB transfer; ready and read data are taken at rising edges
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(n, e, rd)
  endtask
  task automatic irqchk(input logic e);
    @(negedge CLK);
    `CHK("irq", e, IRQ)
  endtask
  // Pulse errors and count the messages and log strobes they cause
  task automatic fire(input logic [20:0] v, input int f, input int n,
                      input int h);
    nf = lm.n_fat;
    nn = lm.n_nfat;
    nh = lm.n_hdr;
    lm.pulse(v);
    repeat (3) @(posedge CLK);
    `CHK("fatal", f, lm.n_fat - nf)
    `CHK("nonfatal", n, lm.n_nfat - nn)
    if (h >= 0) `CHK("hdrlog", h, lm.n_hdr - nh)
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    POR <= 1'b0;
    RST <= 1'b0;
    rdchk("mask", `PCUER_OFS_MASK, 32'h00000000);
    rdchk("sev", `PCUER_OFS_SEVER, 32'h00062011);
    rdchk("stat", `PCUER_OFS_STATUS, 32'h00000000);
    rdchk("corr", `PCUER_OFS_CORSTAT, 32'h00000000);
    rdchk("unmapped", 12'h200, 32'h00000000);
    bus(1'b1, `PCUER_OFS_MASK, 32'hffffffff);
    rdchk("mask", `PCUER_OFS_MASK, 32'h0017f010);
    bus(1'b1, `PCUER_OFS_SEVER, 32'h00000000);
    rdchk("sev", `PCUER_OFS_SEVER, 32'h00000001);
    bus(1'b1, `PCUER_OFS_MASK, 32'h00000000);
    $display("test registers done");
    // Every error alone, under two severity settings; bit 15 is nonfatal in both
    for (int k = 0; k < 2; k++) begin
      sv = k ? 32'h00115000 : 32'h00062011;
      bus(1'b1, `PCUER_OFS_SEVER, sv);
      for (int i = 0; i < 21; i++) if (`PCUER_IMPL_BITS >> i & 1) begin
        bus(1'b1, `PCUER_OFS_STATUS, 32'hffffffff);
        rdchk("stat", `PCUER_OFS_STATUS, 32'h00000000);
        fire(21'h1 << i, sv[i], !sv[i], `PCUER_HDRLOG_BITS >> i & 1);
        rdchk("stat", `PCUER_OFS_STATUS, 32'h1 << i);
        `CHK("first", 5'(i), FIRST_ERR_PTR)
      end
    end
    rdchk("firstreg", `PCUER_OFS_FIRST, 32'h00000034);
    $display("test single errors done");
    bus(1'b1, `PCUER_OFS_MASK, 32'hffffffff);
    bus(1'b1, `PCUER_OFS_STATUS, 32'hffffffff);
    fire(21'h17f010, 0, 0, -1);
    rdchk("stat", `PCUER_OFS_STATUS, 32'h0017f010);
    bus(1'b1, `PCUER_OFS_STATUS, 32'h00001000);
    bus(1'b1, `PCUER_OFS_STATUS, 32'h00000000);
    rdchk("stat", `PCUER_OFS_STATUS, 32'h0017e010);
    irqchk(1'b1);
    bus(1'b1, `PCUER_OFS_IRQMASK, 32'hffffffff);
    irqchk(1'b0);
    rdchk("irqm", `PCUER_OFS_IRQMASK, 32'h0017f010);
    $display("test masking done");
    @(posedge CLK);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    rdchk("stat", `PCUER_OFS_STATUS, 32'h0017e010);
    rdchk("mask", `PCUER_OFS_MASK, 32'h0017f010);
    rdchk("sev", `PCUER_OFS_SEVER, 32'h00115001);
    irqchk(1'b1);
    bus(1'b1, `PCUER_OFS_STATUS, 32'hffffffff);
    irqchk(1'b0);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
